// ==== dv/tb_adc_conversion_control.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end

module tb_adc_conversion_control;

    // ------------------------------------------------------------
    // clock, reset and design ports
    // ------------------------------------------------------------
    logic        clk      = 1'b0;
    logic        rst_n    = 1'b0;
    logic        wb_cyc   = 1'b0;
    logic        wb_stb   = 1'b0;
    logic        wb_we    = 1'b0;
    logic [7:0]  wb_adr   = 8'h00;
    logic [3:0]  wb_sel   = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic        cmp_i    = 1'b0;
    logic [3:0]  trig_i   = 4'h0;
    logic        conv_power_o;
    logic        sample_o;
    logic [9:0]  dac_trial_o;
    logic        irq_o;
    int          err_total    = 0;
    int          total_checks = 0;
    logic [15:0] seed = 16'h0063;
    logic [9:0]  ana  = 10'h000;
    logic [9:0]  res;
    logic [31:0] rd;
    int          n;
    int          s;
    int          k;

    always #12.5 clk = ~clk;

    // comparator follows the trial word of the previous cycle
    always @(posedge clk) cmp_i <= (ana >= dac_trial_o);

    adcc_conversion_control DUT (
        .clk          (clk),
        .rst_n        (rst_n),
        .wb_cyc_i     (wb_cyc),
        .wb_stb_i     (wb_stb),
        .wb_we_i      (wb_we),
        .wb_adr_i     (wb_adr),
        .wb_sel_i     (wb_sel),
        .wb_dat_i     (wb_dat_w),
        .wb_dat_o     (wb_dat_r),
        .wb_ack_o     (wb_ack),
        .cmp_i        (cmp_i),
        .trig_i       (trig_i),
        .conv_power_o (conv_power_o),
        .sample_o     (sample_o),
        .dac_trial_o  (dac_trial_o),
        .irq_o        (irq_o)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    // top k bits kept, the rest copy the lowest kept bit
    function automatic logic [9:0] fill(input logic [9:0] a, input int kk);
        logic [9:0] r;
        r = 10'h000;
        for (int i = 0; i < 10; i++) begin
            if (i >= 10 - kk) r[i] = a[i];
            else if (kk > 0) r[i] = a[10 - kk];
        end
        fill = r;
    endfunction : fill

    function automatic logic partial_ok(input logic [9:0] r, input logic [9:0] a, input int lo, input int hi);
        partial_ok = 1'b0;
        for (int kk = lo; kk <= hi; kk++) begin
            if (r === fill(a, kk)) partial_ok = 1'b1;
        end
    endfunction : partial_ok

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] sl);
        int i;
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= w;
        wb_adr   <= a;
        wb_sel   <= sl;
        wb_dat_w <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (wb_ack === 1'b1) break;
        end
        if (i == 50) begin
            err_total++;
            final_report();
        end
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : wb_xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d, 4'hf);
    endtask : wr

    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        wb_xfer(1'b0, a, 32'h0, 4'hf);
        `CHK(nm, ex, rd)
    endtask : rd_chk

    task rd_res;
        wb_xfer(1'b0, adcc_pkg::OFS_RES_HIGH, 32'h0, 4'hf);
        res[9:8] = rd[1:0];
        wb_xfer(1'b0, adcc_pkg::OFS_RES_LOW, 32'h0, 4'hf);
        res[7:0] = rd[7:0];
    endtask : rd_res

    // cycles from the calling edge until irq_o stands, and cycles of sampling
    task wait_irq;
        n = 0;
        s = 0;
        while (n < 200) begin
            @(negedge clk);
            if (sample_o === 1'b1) s++;
            if (irq_o === 1'b1) break;
            n++;
        end
        if (n == 200) begin
            err_total++;
            final_report();
        end
    endtask : wait_irq

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("ctrl_rst", adcc_pkg::OFS_CTRL, 32'h0);
        rd_chk("status_rst", adcc_pkg::OFS_STATUS, 32'h0);
        rd_chk("mask_rst", adcc_pkg::OFS_MASK, 32'h0);
        rd_chk("unmapped", 8'h14, 32'h0);
        wr(adcc_pkg::OFS_CTRL, 32'h2);
        rd_chk("run_unpowered", adcc_pkg::OFS_CTRL, 32'h0);
        wr(adcc_pkg::OFS_CTRL, 32'h3);
        repeat (8) @(posedge clk);
        rd_chk("power_run_same", adcc_pkg::OFS_CTRL, 32'h1);
        `CHK("power_out", 1'b1, conv_power_o)
        wr(adcc_pkg::OFS_MASK, 32'h3);
        $display("test reset_and_power done");

        for (int t = 0; t < 6; t++) begin
            ana  = (t == 0) ? 10'h000 : (t == 1) ? 10'h3ff : seed[9:0];
            seed = lfsr(seed);
            wr(adcc_pkg::OFS_CTRL, 32'h3);
            wait_irq();
            `CHK("conv_len", 44, n)
            `CHK("sample_len", 4, s)
            rd_res();
            `CHK("result", ana, res)
            rd_chk("done_flag", adcc_pkg::OFS_STATUS, 32'h1);
            rd_chk("run_cleared", adcc_pkg::OFS_CTRL, 32'h1);
            wr(adcc_pkg::OFS_STATUS, 32'h1);
            rd_chk("done_cleared", adcc_pkg::OFS_STATUS, 32'h0);
        end
        $display("test conversions done");

        wr(adcc_pkg::OFS_MASK, 32'h0);
        wr(adcc_pkg::OFS_CTRL, 32'h3);
        repeat (60) @(posedge clk);
        `CHK("irq_masked", 1'b0, irq_o)
        rd_chk("done_masked", adcc_pkg::OFS_STATUS, 32'h1);
        wr(adcc_pkg::OFS_MASK, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq_unmasked", 1'b1, irq_o)
        wr(adcc_pkg::OFS_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq_cleared", 1'b0, irq_o)
        $display("test interrupt done");

        for (int w = 0; w < 45; w += 9) begin
            ana  = seed[9:0];
            seed = lfsr(seed);
            wr(adcc_pkg::OFS_CTRL, 32'h3);
            repeat (w) @(posedge clk);
            wr(adcc_pkg::OFS_CTRL, 32'h1);
            repeat (3) @(posedge clk);
            rd_res();
            k = (w >= 2) ? (w + 2) / 4 - 1 : 0;
            `CHK("partial", 1'b1, partial_ok(res, ana, k, k))
            rd_chk("abort_flag", adcc_pkg::OFS_STATUS, 32'h2);
            rd_chk("abort_idle", adcc_pkg::OFS_CTRL, 32'h1);
            wr(adcc_pkg::OFS_STATUS, 32'h3);
        end
        $display("test abort done");

        for (int ts = 1; ts <= 4; ts++) begin
            ana  = seed[9:0];
            seed = lfsr(seed);
            wr(adcc_pkg::OFS_CTRL, 32'(ts << 2) | 32'h1);
            trig_i <= 4'(1 << (ts % 4));
            repeat (3) @(posedge clk);
            trig_i <= 4'h0;
            repeat (3) @(posedge clk);
            rd_chk("other_trig", adcc_pkg::OFS_CTRL, 32'(ts << 2) | 32'h1);
            trig_i <= 4'(1 << (ts - 1));
            wait_irq();
            trig_i <= 4'h0;
            `CHK("trig_len", 45, n)
            `CHK("trig_sample", 4, s)
            rd_res();
            `CHK("trig_result", ana, res)
            wr(adcc_pkg::OFS_STATUS, 32'h1);
        end
        wr(adcc_pkg::OFS_CTRL, 32'h1);
        wb_xfer(1'b1, adcc_pkg::OFS_CTRL, 32'h0, 4'he);
        rd_chk("sel_gated", adcc_pkg::OFS_CTRL, 32'h1);
        $display("test trigger done");

        wr(adcc_pkg::OFS_CTRL, 32'h3);
        repeat (10) @(posedge clk);
        wr(adcc_pkg::OFS_CTRL, 32'h0);
        repeat (60) @(posedge clk);
        `CHK("power_off", 1'b0, conv_power_o)
        rd_chk("cancel_flag", adcc_pkg::OFS_STATUS, 32'h0);
        wr(adcc_pkg::OFS_CTRL, 32'h1);
        wr(adcc_pkg::OFS_CTRL, 32'h3);
        repeat (10) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK("rst_outputs", 13'h0, {conv_power_o, sample_o, dac_trial_o, irq_o})
        @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("rst_ctrl", adcc_pkg::OFS_CTRL, 32'h0);
        rd_chk("rst_low", adcc_pkg::OFS_RES_LOW, 32'h0);
        rd_chk("rst_mask", adcc_pkg::OFS_MASK, 32'h0);
        repeat (60) @(posedge clk);
        rd_chk("rst_cancel", adcc_pkg::OFS_STATUS, 32'h0);
        $display("test power_off_and_reset done");
        final_report();
    end

endmodule : tb_adc_conversion_control

// ==== logic/adcc_conversion_control.sv ====
// Operation
// - Writing the run flag to one while powered on starts a conversion; the code starts only if the same write keeps the power bit set.
// - On normal completion the hardware clears the run flag.
// - On normal completion the hardware sets the conversion done flag.
// - On normal completion the result is loaded into result high and result low.
// - Writing the run flag to zero during a conversion aborts it and converting stops; the code aborts only if the same write keeps the power bit set.
// - On abort the partial sample is still written into result high and result low.
// - On abort every unresolved result bit copies the most recently resolved bit.
// - Reset returns all registers to reset values, powers off and cancels a conversion.
// - A rising edge of the selected trigger source sets the run flag and starts a conversion; an edge coinciding with a CTRL write is ignored.
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps

module adcc_conversion_control (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        cmp_i,
    input  wire logic [3:0]  trig_i,
    output logic             conv_power_o,
    output logic             sample_o,
    output logic      [9:0]  dac_trial_o,
    output logic             irq_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        adcc_pkg::adcc_state_type state;
        logic                     power;
        logic                     run;
        logic [2:0]               tsel;
        logic [9:0]               sar;
        logic [3:0]               idx;
        logic [9:0]               result;
        logic [1:0]               status;
        logic [1:0]               mask;
        logic                     ack;
        logic [31:0]              rdata;
        logic                     irq;
        logic                     sample;
        logic [9:0]               trial;
    } adcc_regs_type;

    adcc_regs_type s_reg;
    adcc_regs_type s_next;

    logic       step_en;
    logic       trig_level;
    logic       trig_rise;
    logic       req_new;
    logic       wr_hit;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       wr_mask;
    logic       busy;
    logic       start_sw;
    logic       start_hw;
    logic       start;
    logic       abort_sw;
    logic       cancel;
    logic       finish_ev;
    logic       last_bit;
    logic [9:0] final_val;
    logic [9:0] part_val;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] fill_partial(
        input adcc_pkg::adcc_state_type st,
        input logic [9:0]               sar,
        input logic [3:0]               idx,
        input logic                     last
    );
        logic [9:0] val;
        val = sar;
        for (int i = 0; i < adcc_pkg::RES_W; i++) begin
            if (st != adcc_pkg::ST_CONVERT || 4'(i) <= idx) begin
                val[i] = (st == adcc_pkg::ST_CONVERT) ? last : 1'b0;
            end
        end
        return val;
    endfunction : fill_partial

    adcc_step_div u_step_div (
        .clk     (clk),
        .rst_n   (rst_n),
        .clear   (start),
        .step_en (step_en)
    );

    always_comb begin
        unique case (s_reg.tsel)
            3'h1:    trig_level = trig_i[0];
            3'h2:    trig_level = trig_i[1];
            3'h3:    trig_level = trig_i[2];
            3'h4:    trig_level = trig_i[3];
            default: trig_level = 1'b0;
        endcase
    end

    adcc_rise_det u_rise_det (
        .clk   (clk),
        .rst_n (rst_n),
        .level (trig_level),
        .rise  (trig_rise)
    );

    // ------------------------------------------------------------
    // bus decode and events
    // ------------------------------------------------------------
    assign req_new  = wb_cyc_i && wb_stb_i && !s_reg.ack;
    assign wr_hit   = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack && wb_sel_i[0];
    assign wr_ctrl  = wr_hit && wb_adr_i == adcc_pkg::OFS_CTRL;
    assign wr_stat  = wr_hit && wb_adr_i == adcc_pkg::OFS_STATUS;
    assign wr_mask  = wr_hit && wb_adr_i == adcc_pkg::OFS_MASK;
    assign busy     = s_reg.state != adcc_pkg::ST_IDLE;

    // power on gates every start
    // start needs power
    assign start_sw = wr_ctrl && wb_dat_i[adcc_pkg::CTRL_RUN_BIT] && wb_dat_i[adcc_pkg::CTRL_PWR_BIT]
                      && s_reg.power && !busy;
    assign start_hw = trig_rise && s_reg.power && !busy && !wr_ctrl;
    assign start    = start_sw || start_hw;
    assign abort_sw = wr_ctrl && !wb_dat_i[adcc_pkg::CTRL_RUN_BIT] && wb_dat_i[adcc_pkg::CTRL_PWR_BIT]
                      && busy;
    assign cancel   = wr_ctrl && !wb_dat_i[adcc_pkg::CTRL_PWR_BIT] && busy;
    assign finish_ev = s_reg.state == adcc_pkg::ST_CONVERT && step_en && s_reg.idx == 4'h0
                       && !abort_sw && !cancel;

    assign last_bit = (s_reg.idx == adcc_pkg::IDX_TOP) ? 1'b0 : s_reg.sar[s_reg.idx + 4'h1];

    always_comb begin
        final_val    = s_reg.sar;
        final_val[0] = cmp_i;
    end

    assign part_val = fill_partial(s_reg.state, s_reg.sar, s_reg.idx, last_bit);

    assign ev_set = {abort_sw, finish_ev};
    assign ev_clr = wr_stat ? wb_dat_i[1:0] : adcc_pkg::EV_RST;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next     = s_reg;
        s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;

        if (wr_ctrl) begin
            s_next.power = wb_dat_i[adcc_pkg::CTRL_PWR_BIT];
            s_next.tsel  = wb_dat_i[adcc_pkg::CTRL_TSEL_LSB +: adcc_pkg::TSEL_W];
        end
        if (wr_mask) begin
            s_next.mask = wb_dat_i[1:0];
        end

        unique case (s_reg.state)
            adcc_pkg::ST_IDLE: begin
                if (start) begin
                    s_next.state = adcc_pkg::ST_SAMPLE;
                    s_next.run   = 1'b1;
                    s_next.sar   = adcc_pkg::RESULT_RST;
                    s_next.idx   = adcc_pkg::IDX_TOP;
                end
            end
            adcc_pkg::ST_SAMPLE: begin
                if (step_en) begin
                    s_next.state = adcc_pkg::ST_CONVERT;
                end
            end
            adcc_pkg::ST_CONVERT: begin
                if (step_en) begin
                    s_next.sar[s_reg.idx] = cmp_i;
                    if (s_reg.idx == 4'h0) begin
                        s_next.state = adcc_pkg::ST_IDLE;
                        s_next.run   = 1'b0;
                        s_next.result = final_val;
                    end else begin
                        s_next.idx = s_reg.idx - 4'h1;
                    end
                end
            end
            default: begin
                s_next.state = adcc_pkg::ST_IDLE;
                s_next.run   = 1'b0;
            end
        endcase

        if (abort_sw) begin
            s_next.state  = adcc_pkg::ST_IDLE;
            s_next.run    = 1'b0;
            s_next.sar    = s_reg.sar;
            s_next.result = part_val;
        end
        if (cancel) begin
            s_next.state  = adcc_pkg::ST_IDLE;
            s_next.run    = 1'b0;
            s_next.sar    = s_reg.sar;
            s_next.result = s_reg.result;
        end

        s_next.status = (s_reg.status & ~ev_clr) | ev_set;

        s_next.irq    = |(s_next.status & s_next.mask);
        s_next.sample = s_next.state == adcc_pkg::ST_SAMPLE;
        s_next.trial  = (s_next.state == adcc_pkg::ST_CONVERT) ? (s_next.sar | (10'h001 << s_next.idx))
                                                                : adcc_pkg::RESULT_RST;

        if (req_new) begin
            unique case (wb_adr_i)
                adcc_pkg::OFS_CTRL:     s_next.rdata = {24'h000000, busy, 2'h0, s_reg.tsel, s_reg.run, s_reg.power};
                adcc_pkg::OFS_RES_HIGH: s_next.rdata = {30'h00000000, s_reg.result[9:8]};
                adcc_pkg::OFS_RES_LOW:  s_next.rdata = {24'h000000, s_reg.result[7:0]};
                adcc_pkg::OFS_STATUS:   s_next.rdata = {30'h00000000, s_reg.status};
                adcc_pkg::OFS_MASK:     s_next.rdata = {30'h00000000, s_reg.mask};
                default:                s_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg        <= '0;
            s_reg.state  <= adcc_pkg::ST_IDLE;
            s_reg.idx    <= adcc_pkg::IDX_TOP;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o     = s_reg.rdata;
    assign wb_ack_o     = s_reg.ack;
    assign conv_power_o = s_reg.power;
    assign sample_o     = s_reg.sample;
    assign dac_trial_o  = s_reg.trial;
    assign irq_o        = s_reg.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam logic [7:0] CHK_LAST = 8'(adcc_pkg::CONV_CYCLES - 1);

    logic [7:0] busy_cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt <= 8'h00;
        end else if (start) begin
            busy_cnt <= 8'h00;
        end else if (busy) begin
            busy_cnt <= busy_cnt + 8'h01;
        end
    end

    default clocking chk_cb @(posedge clk);
    endclocking

    default disable iff (!rst_n);

    sequence s_started;
        start ##1 s_reg.run;
    endsequence

    sequence s_sampling;
        s_reg.sample [*4];
    endsequence

    sequence s_sample_end;
        !s_reg.sample && s_reg.state == adcc_pkg::ST_CONVERT;
    endsequence

    start_conv_a: assert property (start_sw |=> s_reg.state == adcc_pkg::ST_SAMPLE && s_reg.run)
        else $error("software start did not begin a conversion");

    run_clear_a: assert property (finish_ev |=> !s_reg.run && !busy)
        else $error("run flag still set after completion");

    done_flag_a: assert property (finish_ev |=> s_reg.status[adcc_pkg::ST_DONE_BIT])
        else $error("done flag not set at completion");

    result_load_a: assert property (finish_ev |=> s_reg.result == $past(final_val))
        else $error("result not loaded at completion");

    abort_stop_a: assert property (abort_sw |=> !busy && !s_reg.run && !s_reg.sample)
        else $error("abort did not stop the conversion");

    abort_result_a: assert property (abort_sw |=> s_reg.result == $past(part_val))
        else $error("partial result not stored on abort");

    partial_fill_a: assert property (abort_sw && s_reg.state == adcc_pkg::ST_CONVERT
                                     && s_reg.idx != adcc_pkg::IDX_TOP |=> s_reg.result[0] == $past(last_bit))
        else $error("unresolved bits do not copy the last resolved bit");

    reset_off_a: assert property ($rose(rst_n) |-> !conv_power_o && !s_reg.run && !busy && !irq_o)
        else $error("reset left the converter active");

    trig_start_a: assert property (start_hw |-> s_started)
        else $error("trigger edge did not start a conversion");

    sample_hold_a: assert property (disable iff (!rst_n || abort_sw || cancel)
                                    start |-> s_started ##0 s_sampling ##1 s_sample_end)
        else $error("sampling phase has the wrong length");

    conv_length_a: assert property (finish_ev |-> busy_cnt == CHK_LAST)
        else $error("conversion length differs from the fixed step count");

    no_power_start_a: assert property (!s_reg.power |-> !start)
        else $error("conversion started while the converter was off");

    cancel_stop_a: assert property (cancel |=> !busy && !s_reg.run && s_reg.result == $past(s_reg.result))
        else $error("power off did not cancel the conversion");

    busy_run_a: assert property (s_reg.run == busy)
        else $error("run flag and conversion state disagree");

    irq_level_a: assert property (irq_o == |(s_reg.status & s_reg.mask))
        else $error("interrupt level does not follow status and mask");

    trial_idle_a: assert property (s_reg.state != adcc_pkg::ST_CONVERT |-> dac_trial_o == '0)
        else $error("trial word driven outside the bit phase");

    reset_result_a: assert property ($rose(rst_n) |-> s_reg.result == adcc_pkg::RESULT_RST
                                     && s_reg.status == adcc_pkg::EV_RST)
        else $error("reset left a result or a status flag");

endmodule : adcc_conversion_control

// ==== logic/adcc_pkg.sv ====
package adcc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned ADR_W          = 8;
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_RES_HIGH   = 8'h04;
    localparam logic [7:0]  OFS_RES_LOW    = 8'h08;
    localparam logic [7:0]  OFS_STATUS     = 8'h0c;
    localparam logic [7:0]  OFS_MASK       = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_PWR_BIT   = 0;
    localparam int unsigned CTRL_RUN_BIT   = 1;
    localparam int unsigned CTRL_TSEL_LSB  = 2;
    localparam int unsigned TSEL_W         = 3;
    localparam int unsigned CTRL_BUSY_BIT  = 7;
    localparam int unsigned ST_DONE_BIT    = 0;
    localparam int unsigned ST_ABORT_BIT   = 1;
    localparam int unsigned EV_W           = 2;
    localparam int unsigned TRIG_N         = 4;

    // ------------------------------------------------------------
    // result layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned RES_W          = 10;
    localparam int unsigned IDX_W          = 4;
    localparam int unsigned RES_HIGH_W     = 2;
    localparam logic [9:0]  RESULT_RST     = 10'h000;
    localparam logic [3:0]  IDX_TOP        = 4'h9;
    localparam logic [2:0]  TSEL_RST       = 3'h0;
    localparam logic [1:0]  EV_RST         = 2'h0;

    // ------------------------------------------------------------
    // timing: one converter clock period per step
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned CONV_TCK_NS    = 100;
    localparam int unsigned CONV_DIV       = (CONV_TCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_STEPS     = RES_W + 1;
    localparam int unsigned CONV_CYCLES    = CONV_STEPS * CONV_DIV;
    localparam int unsigned DIV_W          = 8;
    localparam logic [7:0]  DIV_LAST       = 8'(CONV_DIV - 1);

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h1,
        ST_SAMPLE  = 3'h2,
        ST_CONVERT = 3'h4
    } adcc_state_type;

endpackage : adcc_pkg

// ==== logic/adcc_rise_det.sv ====
`timescale 1ns/1ps

module adcc_rise_det (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic level,
    output logic      rise
);

    typedef struct packed {
        logic prev;
    } adcc_rise_type;

    adcc_rise_type rise_reg;
    adcc_rise_type rise_next;

    always_comb begin
        rise_next      = rise_reg;
        rise_next.prev = level;
    end

    assign rise = level && !rise_reg.prev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_reg <= '0;
        end else begin
            rise_reg <= rise_next;
        end
    end

endmodule : adcc_rise_det

// ==== logic/adcc_step_div.sv ====
`timescale 1ns/1ps

module adcc_step_div (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clear,
    output logic      step_en
);

    typedef struct packed {
        logic [adcc_pkg::DIV_W-1:0] count;
    } adcc_div_type;

    adcc_div_type div_reg;
    adcc_div_type div_next;

    // restarts on clear so every conversion has the same length
    always_comb begin
        div_next = div_reg;
        if (clear || div_reg.count == adcc_pkg::DIV_LAST) begin
            div_next.count = '0;
        end else begin
            div_next.count = div_reg.count + 8'h01;
        end
    end

    assign step_en = !clear && div_reg.count == adcc_pkg::DIV_LAST;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

endmodule : adcc_step_div
